// file: async_split_descriptor.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module async_split_descriptor
  import split_desc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transaction request
  output logic cmd_valid,
  input wire logic cmd_ready,
  output exec_cmd_type cmd,
  // Transaction result
  input wire logic result_valid,
  input wire exec_result_type result
);

  // ---------------------------------------------------------------
  // Descriptor storage and state
  // ---------------------------------------------------------------
  logic [31:0] word_q [4];
  logic [31:0] word_d [4];
  logic [1:0] cerr_init_q;
  logic [1:0] cerr_init_d;
  state_type state_q;
  state_type state_d;
  logic bus_ack_q;
  logic bus_ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  exec_cmd_type cmd_q;
  exec_cmd_type cmd_d;

  logic [31:0] be_mask;
  logic [14:0] done_sum;
  logic [1:0] cerr_now;
  logic [3:0] nak_now;
  logic [3:0] reload_now;
  logic [14:0] total_now;
  logic [14:0] done_now;
  logic [10:0] maxlen_now;

  // ---------------------------------------------------------------
  // Byte lane mask
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_lane
      assign be_mask[g*8 +: 8] = {8{avs_byteenable[g]}};
    end
  endgenerate

  assign cerr_now = word_q[3][CERR_LSB +: 2];
  assign nak_now = word_q[3][NAK_RETRY_COUNTER_LSB +: 4];
  assign reload_now = word_q[2][RELOAD_LSB +: 4];
  assign total_now = word_q[0][TOTAL_LSB +: TOTAL_W];
  assign done_now = word_q[3][DONE_LSB +: TOTAL_W];
  assign maxlen_now = word_q[0][MAXLEN_LSB +: MAXLEN_W];
  assign done_sum = done_now + {4'h0, result.bytes};

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
  assign avs_readdata = rdata_q;
  assign cmd_valid = (state_q == ST_ISSUE);
  assign cmd = cmd_q;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wmask;
    logic set_xerr;
    logic set_halt;
    wmask = 32'h00000000;
    set_xerr = 1'b0;
    set_halt = 1'b0;
    word_d = word_q;
    cerr_init_d = cerr_init_q;
    state_d = state_q;
    bus_ack_d = 1'b0;
    rdata_d = rdata_q;
    cmd_d = cmd_q;

    // Execution
    case (state_q)
      ST_IDLE: begin
        if (word_q[0][ACTIVE_POS]) begin
          state_d = ST_ISSUE;
          cmd_d.split = word_q[1][SPLIT_POS];
          cmd_d.hub_addr = word_q[1][HUB_LSB +: 7];
          cmd_d.hub_port_index = word_q[1][PORT_LSB +: 7];
          // Rate code only carries meaning for splits
          cmd_d.line_rate_code = word_q[1][SPLIT_POS] ?
            word_q[1][RATE_LSB +: 2] : RATE_FULL;
          cmd_d.endpoint_kind = word_q[1][KIND_LSB +: 2];
          cmd_d.token = word_q[1][TOKEN_LSB +: 2];
          cmd_d.function_addr = word_q[1][FADDR_LSB +: 7];
          cmd_d.endpoint_number = {word_q[1][EP_HI_LSB +: 3],
                                   word_q[0][EP_LSB_POS]};
          cmd_d.max_payload_len = maxlen_now;
          cmd_d.payload_buffer_pointer = word_q[2][PTR_LSB +: PTR_W];
        end
      end
      ST_ISSUE: begin
        if (!word_q[0][ACTIVE_POS]) begin
          state_d = ST_IDLE;
        end else if (cmd_ready) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (result_valid) begin
          state_d = ST_IDLE;
          case (result.code)
            RES_ACK: begin
              word_d[3][DONE_LSB +: TOTAL_W] = done_sum;
              // Short packet or byte total reached ends the descriptor
              if (done_sum >= total_now || result.bytes < maxlen_now) begin
                word_d[0][ACTIVE_POS] = 1'b0;
              end
              word_d[3][CERR_LSB +: 2] = cerr_init_q;
            end
            RES_NAK, RES_NYET: begin
              word_d[3][CERR_LSB +: 2] = cerr_init_q;
              if (result.code == RES_NAK && reload_now != 4'h0) begin
                word_d[3][NAK_RETRY_COUNTER_LSB +: 4] = nak_now - 4'h1;
                if (nak_now <= 4'h1) begin
                  word_d[3][NAK_RETRY_COUNTER_LSB +: 4] = 4'h0;
                  word_d[0][ACTIVE_POS] = 1'b0;
                end
              end
            end
            RES_BAD: begin
              if (cerr_now <= 2'h1) begin
                word_d[3][CERR_LSB +: 2] = 2'h0;
                word_d[3][XERR_POS] = 1'b1;
                set_xerr = 1'b1;
                word_d[0][ACTIVE_POS] = 1'b0;
              end else begin
                word_d[3][CERR_LSB +: 2] = cerr_now - 2'h1;
              end
            end
            default: begin
              word_d[3][HALT_POS] = 1'b1;
              set_halt = 1'b1;
              word_d[0][ACTIVE_POS] = 1'b0;
            end
          endcase
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Register access
    if ((avs_read | avs_write) && !bus_ack_q) begin
      bus_ack_d = 1'b1;
      rdata_d = 32'h00000000;
      case (avs_address)
        OFS_WORD0: begin
          rdata_d = word_q[0];
          wmask = MASK_WORD0;
        end
        OFS_WORD1: begin
          rdata_d = word_q[1];
          wmask = MASK_WORD1;
        end
        OFS_WORD2: begin
          rdata_d = word_q[2];
          wmask = MASK_WORD2;
        end
        OFS_WORD3: begin
          rdata_d = word_q[3];
          wmask = MASK_WORD3;
        end
        OFS_STATE: begin
          rdata_d = {29'h00000000, state_q};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
      if (avs_write) begin
        wmask = wmask & be_mask;
        case (avs_address)
          OFS_WORD0: word_d[0] = (word_d[0] & ~wmask) | (avs_writedata & wmask);
          OFS_WORD1: word_d[1] = (word_d[1] & ~wmask) | (avs_writedata & wmask);
          OFS_WORD2: word_d[2] = (word_d[2] & ~wmask) | (avs_writedata & wmask);
          OFS_WORD3: begin
            word_d[3] = (word_d[3] & ~wmask) | (avs_writedata & wmask);
            if (avs_byteenable[2] | avs_byteenable[3]) begin
              cerr_init_d = avs_writedata[CERR_LSB +: 2];
            end
          end
          default: begin
            wmask = 32'h00000000;
          end
        endcase
      end
    end

    // Error flags raised by hardware win over a same-cycle clear
    word_d[3][XERR_POS] = word_d[3][XERR_POS] | set_xerr;
    word_d[3][HALT_POS] = word_d[3][HALT_POS] | set_halt;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        word_q[i] <= RESET_WORD;
      end
      cerr_init_q <= 2'h0;
      state_q <= ST_IDLE;
      bus_ack_q <= 1'b0;
      rdata_q <= RESET_WORD;
      cmd_q <= '0;
    end else begin
      word_q <= word_d;
      cerr_init_q <= cerr_init_d;
      state_q <= state_d;
      bus_ack_q <= bus_ack_d;
      rdata_q <= rdata_d;
      cmd_q <= cmd_d;
    end
  end

endmodule // async_split_descriptor

// file: split_bulk_descriptor_fields_tb_top.sv
`timescale 1ns/100ps
module split_bulk_descriptor_fields_tb_top import split_desc_pkg::*; ;
  // ----
  // Signals
  // ----
  logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic cmd_valid, cmd_ready, avs_waitrequest, result_valid;
  logic [4:0] avs_address = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, avs_readdata, r = 32'h70fc;
  logic [31:0] m [4] = '{MASK_WORD0, MASK_WORD1, MASK_WORD2, MASK_WORD3};
  exec_cmd_type cmd;
  exec_result_type result;
  result_type code_in = RES_ACK;
  logic [10:0] bytes_in = '0;
  int num_errors = 0, checks = 0, cyc = 0, i;
  logic [63:0] rd_q[$], cmd_q[$];

  async_split_descriptor i_async_split_descriptor (.sys_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .cmd_valid, .cmd_ready, .cmd, .result_valid, .result);
  split_tt_model i_split_tt_model (.sys_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd,
    .result_valid, .result, .stall(r[3]), .code_in, .bytes_in);

  always #2 sys_clk = ~sys_clk;

  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  always @(posedge sys_clk) r <= lfsr(r);

  // ----
  // Tasks
  // ----
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back({32'h0, e});
    bus(1'b0, a, 32'h0);
  endtask
  function logic [63:0] mk(input logic [31:0] w0, w1, w2);
    return 64'({w1[14], w1[31:18], w1[17:16], w1[13:10], w1[9:3], w1[2:0], w0[31],
      w0[28:18], w2[23:8]});
  endfunction
  task launch(input logic [31:0] w0, w1, w2, w3, input result_type c,
    input logic [10:0] b, input logic [31:0] e3);
    int n;
    code_in <= c;
    bytes_in <= b;
    cmd_q.push_back(mk(w0, w1, w2));
    bus(1'b1, OFS_WORD1, w1);
    bus(1'b1, OFS_WORD2, w2);
    bus(1'b1, OFS_WORD3, w3);
    bus(1'b1, OFS_WORD0, w0 | 32'h1);
    for (n = 0; n < 100 && result_valid !== 1'b1; n++) @(posedge sys_clk);
    @(posedge sys_clk);
    rd(OFS_WORD0, w0 & MASK_WORD0 & ~32'h1);
    rd(OFS_WORD3, e3);
    rd(OFS_STATE, 32'h1);
    $display("launch done");
  endtask

  // ----
  // Monitor and run
  // ----
  always @(posedge sys_clk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0) check(64'(avs_readdata), rd_q.pop_front());
    if (cmd_valid && cmd_ready === 1'b1) check(64'(cmd), cmd_q.pop_front());
    if (cyc == 20000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (i = 0; i < 5; i++) rd(5'(4 * i), (i == 4) ? 32'h1 : 32'h0);
    bus(1'b1, 5'h14, 32'hffffffff);
    rd(5'h14, 32'h0);
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      bus(1'b1, 5'(4 * (i % 4)), r & ~32'h1);
      rd(5'(4 * (i % 4)), avs_writedata & m[i % 4]);
    end
    $display("field test done");
    launch(32'h81000040, 32'h000e602d, 32'h00123400, 32'h0, RES_ACK, 11'd8, 32'h8);
    launch(32'h00200080, 32'h0a0443f8, 32'h00123400, 32'h0, RES_FATAL, 11'd0,
      32'h40000000);
    launch(32'h81000040, 32'h000e602d, 32'h00123400, 32'h00800000, RES_BAD, 11'd0,
      32'h10000000);
    launch(32'h08000800, 32'h00002009, 32'h02123400, 32'h00080000, RES_NAK, 11'd0,
      32'h0);
    launch(32'h81000080, 32'h000e602d, 32'h00123400, 32'h0, RES_ACK, 11'd5, 32'h5);
    print_verdict;
  end
endmodule // split_bulk_descriptor_fields_tb_top

// file: split_chk.sv
`timescale 1ns/100ps
module split_chk
  import split_desc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire exec_cmd_type cmd
);
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_wait_first;
    $rose(avs_read | avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  property p_wait_one;
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_idle_nowait;
    !(avs_read | avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("idle wait");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > OFS_STATE |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_state_read;
    avs_read && !avs_waitrequest && avs_address == OFS_STATE
      |-> avs_readdata inside {32'h1, 32'h2, 32'h4};
  endproperty
  a_state_read: assert property (p_state_read) else $error("bad state");
  property p_reset_quiet;
    $fell(sys_rst) |-> !cmd_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("cmd after reset");
  property p_cmd_hold;
    cmd_valid && !cmd_ready |=> $stable(cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("cmd changed");
  property p_one_out;
    cmd_valid && cmd_ready |=> !cmd_valid [*2];
  endproperty
  a_one_out: assert property (p_one_out) else $error("second cmd");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_cmd: cover property (cmd_valid && cmd_ready);
endmodule // split_chk

bind async_split_descriptor split_chk i_split_chk (.sys_clk, .sys_rst, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cmd_valid, .cmd_ready, .cmd);

// file: split_desc_pkg.sv
package split_desc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_WORD0 = 5'h00;
  localparam logic [4:0] OFS_WORD1 = 5'h04;
  localparam logic [4:0] OFS_WORD2 = 5'h08;
  localparam logic [4:0] OFS_WORD3 = 5'h0c;
  localparam logic [4:0] OFS_STATE = 5'h10;

  // ---------------------------------------------------------------
  // Word 0 fields
  // ---------------------------------------------------------------
  localparam int ACTIVE_POS = 0;
  localparam int TOTAL_LSB = 3;
  localparam int TOTAL_W = 15;
  localparam int MAXLEN_LSB = 18;
  localparam int MAXLEN_W = 11;
  localparam int EP_LSB_POS = 31;

  // ---------------------------------------------------------------
  // Word 1 fields
  // ---------------------------------------------------------------
  localparam int EP_HI_LSB = 0;
  localparam int FADDR_LSB = 3;
  localparam int TOKEN_LSB = 10;
  localparam int KIND_LSB = 12;
  localparam int SPLIT_POS = 14;
  localparam int RATE_LSB = 16;
  localparam int PORT_LSB = 18;
  localparam int HUB_LSB = 25;

  // ---------------------------------------------------------------
  // Word 2 and word 3 fields
  // ---------------------------------------------------------------
  localparam int PTR_LSB = 8;
  localparam int PTR_W = 16;
  localparam int RELOAD_LSB = 25;
  localparam int DONE_LSB = 0;
  localparam int NAK_RETRY_COUNTER_LSB = 19;
  localparam int CERR_LSB = 23;
  localparam int XERR_POS = 28;
  localparam int HALT_POS = 30;

  // ---------------------------------------------------------------
  // Writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] MASK_WORD0 = 32'h9ffffff9;
  localparam logic [31:0] MASK_WORD1 = 32'hffff7fff;
  localparam logic [31:0] MASK_WORD2 = 32'h1effff00;
  localparam logic [31:0] MASK_WORD3 = 32'h51ff7fff;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_LOW = 2'h2;
  localparam logic [1:0] KIND_CONTROL = 2'h0;
  localparam logic [1:0] KIND_BULK = 2'h2;
  localparam logic [1:0] TOKEN_OUT = 2'h0;

  typedef enum logic [2:0] {
    RES_ACK = 3'h0,
    RES_NAK = 3'h1,
    RES_NYET = 3'h2,
    RES_BAD = 3'h3,
    RES_FATAL = 3'h4
  } result_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ISSUE = 3'h2,
    ST_WAIT = 3'h4
  } state_type;

  typedef struct packed {
    logic split;
    logic [6:0] hub_addr;
    logic [6:0] hub_port_index;
    logic [1:0] line_rate_code;
    logic [1:0] endpoint_kind;
    logic [1:0] token;
    logic [6:0] function_addr;
    logic [3:0] endpoint_number;
    logic [10:0] max_payload_len;
    logic [15:0] payload_buffer_pointer;
  } exec_cmd_type;

  typedef struct packed {
    result_type code;
    logic [10:0] bytes;
  } exec_result_type;

endpackage

// file: split_tt_model.sv
`timescale 1ns/100ps
module split_tt_model
  import split_desc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire exec_cmd_type cmd,
  // Result
  output logic result_valid,
  output exec_result_type result,
  // Scenario control
  input wire logic stall,
  input wire result_type code_in,
  input wire logic [10:0] bytes_in
);
  // ----
  // Far side
  // ----
  logic busy_q;
  logic [1:0] wait_q;
  always @(posedge sys_clk) begin
    cmd_ready <= 1'b0;
    result_valid <= 1'b0;
    result <= exec_result_type'(~result);
    if (sys_rst) begin
      busy_q <= 1'b0;
      result <= '0;
    end else if (busy_q) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h0) begin
        busy_q <= 1'b0;
        result_valid <= 1'b1;
        result <= '{code_in, bytes_in};
      end
    end else if (cmd_valid && cmd_ready) begin
      busy_q <= 1'b1;
      wait_q <= 2'h3;
    end else begin
      cmd_ready <= cmd_valid && !stall;
    end
  end
endmodule // split_tt_model
